// [core/rxfmt_pkg.sv]
// Package for the receive system-side output formatter.
// Assumes one framer per instance, registers reached over a 32-bit APB.
package rxfmt_pkg;
    // ==========================================================
    // Register indices; the byte address is four times the index.
    localparam logic [9:0] IDX_T1_MODE = 10'h001;
    localparam logic [9:0] IDX_ALARM = 10'h007;
    localparam logic [9:0] IDX_EDGE = 10'h010;
    localparam logic [9:0] IDX_FPCFG = 10'h011;
    localparam logic [9:0] IDX_PARITY = 10'h012;
    localparam logic [9:0] IDX_TIMESLOT_OFFSET = 10'h013;
    localparam logic [9:0] IDX_BIT_OFFSET_VAL = 10'h014;
    localparam logic [9:0] IDX_SYSCFG = 10'h020;
    localparam logic [9:0] IDX_STATUS = 10'h021;
    // ==========================================================
    // Writable bits of each register; the rest read as zero.
    localparam logic [7:0] MASK_T1_MODE = 8'hD8;
    localparam logic [7:0] MASK_ALARM = 8'h02;
    localparam logic [7:0] MASK_EDGE = 8'h1C;
    localparam logic [7:0] MASK_FPCFG = 8'h25;
    localparam logic [7:0] MASK_PARITY = 8'hFB;
    localparam logic [7:0] MASK_TIMESLOT_OFFSET = 8'h7F;
    localparam logic [7:0] MASK_BIT_OFFSET_VAL = 8'h0F;
    localparam logic [7:0] MASK_SYSCFG = 8'h0F;
    localparam logic [7:0] REG_RESET = 8'h00;
    // ==========================================================
    // Field positions.
    localparam int DBL_RATE_BIT = 2;
    localparam int FRAME_EDGE_BIT = 3;
    localparam int DATA_EDGE_BIT = 4;
    localparam int FRAME_PULSE_MODE_BIT = 5;
    localparam int SMFP_BIT = 2;
    localparam int ALTFP_BIT = 0;
    localparam int PTYPE_BIT = 7;
    localparam int PEN_BIT = 6;
    localparam int FORCE_EN_BIT = 5;
    localparam int FORCE_VAL_BIT = 4;
    localparam int PEXT_BIT = 3;
    localparam int BIT_OFFSET_EN_BIT = 3;
    localparam int ALARM_BIT = 1;
    localparam int CLK2M_BIT = 4;
    localparam int CLK8M_BIT = 3;
    // ==========================================================
    // Clock-edge counts from the frame reference to frame start.
    localparam logic [12:0] CET_FP0_SAME = 13'h0004;
    localparam logic [12:0] CET_FP0_DIFF = 13'h0003;
    localparam logic [12:0] CET_FP1_SAME = 13'h0002;
    localparam logic [12:0] CET_FP1_DIFF = 13'h0001;
    localparam logic [12:0] LEAD_SAME = 13'h0002;
    localparam logic [12:0] LEAD_DIFF = 13'h0003;
    localparam logic [1:0] EDGES_SINGLE = 2'h1;
    localparam logic [1:0] EDGES_DOUBLE = 2'h3;
    // T1/J1 interface modes.
    typedef enum logic [1:0] {
        RXFMT_MASTER_FRAC = 2'b00,
        RXFMT_MASTER_FULL = 2'b01,
        RXFMT_SLAVE_REF = 2'b10,
        RXFMT_SLAVE_EXTSIG = 2'b11
    } rxfmt_mode_e;
endpackage

// [core/rxfmt_top.sv]
// Receive system-side output formatter for one framer of an octal framer.
// Assumes the framer core hands over one bit per request on pclk, and the
// backplane supplies a common clock and frame pulse from another domain.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module rxfmt_top
    import rxfmt_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int FRAME_BITS = 256
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_sys_common_clk,
    input wire logic rx_common_frame_in,
    input wire logic [6:0] peer_frame_pulse_mode,
    input wire logic [6:0] peer_rate_mux_sel,
    input wire logic rx_bit_in,
    input wire logic rx_sig_in,
    output logic rx_bit_take,
    output logic rx_sys_data_out,
    output logic rx_sys_data_oe_n,
    output logic rx_sys_signaling_out,
    output logic rx_sys_signaling_oe_n,
    output logic rx_frame_pulse_out,
    output logic t1_mux_active
);
    // ==========================================================
    // Elaboration checks: counters are 13 bits and frames hold whole slots.
    if (ADDR_W < 12 || ADDR_W > 32) begin : g_bad_addr
        $error("ADDR_W must lie between 12 and 32.");
    end
    if (FRAME_BITS < 32 || FRAME_BITS > 1024 || (FRAME_BITS % 8) != 0) begin : g_bad_frame
        $error("FRAME_BITS must be a multiple of 8 between 32 and 1024.");
    end

    // Returns the writable mask of a register, and a hit bit on top.
    function automatic logic [8:0] reg_decode(input logic [9:0] idx);
        logic [8:0] r;
        r = 9'h000;
        case (idx)
            IDX_T1_MODE: r = {1'b1, MASK_T1_MODE};
            IDX_ALARM: r = {1'b1, MASK_ALARM};
            IDX_EDGE: r = {1'b1, MASK_EDGE};
            IDX_FPCFG: r = {1'b1, MASK_FPCFG};
            IDX_PARITY: r = {1'b1, MASK_PARITY};
            IDX_TIMESLOT_OFFSET: r = {1'b1, MASK_TIMESLOT_OFFSET};
            IDX_BIT_OFFSET_VAL: r = {1'b1, MASK_BIT_OFFSET_VAL};
            IDX_SYSCFG: r = {1'b1, MASK_SYSCFG};
            IDX_STATUS: r = {1'b1, 8'h00};
            default: r = 9'h000;
        endcase
        return r;
    endfunction

    // ==========================================================
    // Register bank.
    localparam int NREG = 8;
    localparam logic [9:0] REG_IDX [NREG] = '{IDX_T1_MODE, IDX_ALARM, IDX_EDGE, IDX_FPCFG,
                                             IDX_PARITY, IDX_TIMESLOT_OFFSET, IDX_BIT_OFFSET_VAL, IDX_SYSCFG};
    logic [7:0] cfg_reg [NREG];
    logic [7:0] status_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    wire [9:0] acc_idx = paddr[11:2];
    wire acc_aligned = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:2] == (ADDR_W-2)'(acc_idx));
    wire [8:0] acc_dec = reg_decode(acc_idx);
    wire acc_hit = acc_dec[8] && acc_aligned;
    wire acc_setup = psel && !penable && !pready_reg;
    wire acc_commit = psel && penable && pready_reg;

    // Read data selection; unmapped addresses read zero.
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        for (int i = 0; i < NREG; i++) begin
            if (acc_idx == REG_IDX[i]) begin
                rd_byte = cfg_reg[i];
            end
        end
        if (acc_idx == IDX_STATUS) begin
            rd_byte = status_reg;
        end
        if (!acc_hit) begin
            rd_byte = 8'h00;
        end
    end

    // One-cycle answer: pready rises in the access phase after setup.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else if (ce) begin
            pready_reg <= acc_setup;
            pslverr_reg <= acc_setup && !acc_hit;
            prdata_reg <= acc_setup ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    // Each register stores only its defined bits, so reserved bits stay zero.
    for (genvar g = 0; g < NREG; g++) begin : g_cfg
        wire [7:0] m = 8'(reg_decode(REG_IDX[g]));
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cfg_reg[g] <= REG_RESET;
            end else if (ce && acc_commit && pwrite && acc_hit && acc_idx == REG_IDX[g]) begin
                cfg_reg[g] <= pwdata[7:0] & m;
            end
        end
    end

    // ==========================================================
    // Configuration fields.
    wire [7:0] t1m = cfg_reg[0];
    wire [7:0] alm = cfg_reg[1];
    wire [7:0] edg = cfg_reg[2];
    wire [7:0] fpc = cfg_reg[3];
    wire [7:0] par = cfg_reg[4];
    wire [7:0] tso = cfg_reg[5];
    wire [7:0] bof = cfg_reg[6];
    wire [7:0] sys = cfg_reg[7];
    wire double_rate_clk_sel = edg[DBL_RATE_BIT];
    wire frame_edge_sel = edg[FRAME_EDGE_BIT];
    wire data_edge_sel = edg[DATA_EDGE_BIT];
    wire frame_pulse_mode = fpc[FRAME_PULSE_MODE_BIT];
    wire sig_multiframe_pulse_sel = fpc[SMFP_BIT];
    wire alternate_pulse_sel = fpc[ALTFP_BIT];
    wire parity_type_sel = par[PTYPE_BIT];
    wire parity_insert_en = par[PEN_BIT];
    wire force_first_bit_en = par[FORCE_EN_BIT];
    wire forced_bit_value = par[FORCE_VAL_BIT];
    wire parity_include_first_bit = par[PEXT_BIT];
    wire [1:0] tri_ctrl = par[1:0];
    wire [6:0] timeslot_offset = tso[6:0];
    wire bit_offset_en = bof[BIT_OFFSET_EN_BIT];
    wire [2:0] bit_offset_val = bof[2:0];
    wire rx_alarm_force_ones = alm[ALARM_BIT];
    wire [1:0] interface_mode = t1m[7:6];
    wire sysclk_2m_sel = t1m[CLK2M_BIT];
    wire sysclk_8m_sel = t1m[CLK8M_BIT];
    wire t1_sel = sys[0];
    wire clk_master = sys[1];
    wire mux_mode = sys[2];
    wire frac_fbit_mode = sys[3];

    // ==========================================================
    // Offset arithmetic, all in link clock edges.
    // Master mode ignores the common frame input whatever software wrote.
    wire frame_pulse_mode_eff = !clk_master && (mux_mode ? (frame_pulse_mode || (|peer_frame_pulse_mode))
                                               : frame_pulse_mode);
    wire edges_match = (frame_edge_sel == data_edge_sel);
    wire bit_offset_val_use = bit_offset_en && !double_rate_clk_sel;
    wire [12:0] bit_offset_val_edges = bit_offset_val_use ? {9'h000, bit_offset_val, 1'b0} : 13'h0000;
    wire [12:0] cet_base = frame_pulse_mode_eff ? (edges_match ? CET_FP1_SAME : CET_FP1_DIFF)
                                      : (edges_match ? CET_FP0_SAME : CET_FP0_DIFF);
    wire [12:0] ts_edges = double_rate_clk_sel ? {1'b0, timeslot_offset, 5'h00}
                                               : {2'b00, timeslot_offset, 4'h0};
    wire [12:0] offset_edges = cet_base + bit_offset_val_edges + ts_edges;
    wire [1:0] epb_last = double_rate_clk_sel ? EDGES_DOUBLE : EDGES_SINGLE;
    wire [12:0] frame_last = 13'(FRAME_BITS * (int'(epb_last) + 1) - 1);
    wire lead_active = sig_multiframe_pulse_sel && alternate_pulse_sel && !(bit_offset_en && !frame_pulse_mode_eff);
    wire [12:0] lead_edges = (edges_match ? LEAD_SAME : LEAD_DIFF) << double_rate_clk_sel;

    // ==========================================================
    // Synchronisers: link clock and common frame input come from the backplane.
    logic lclk_s1_reg, lclk_s2_reg, lclk_s3_reg;
    logic fin_s1_reg, fin_s2_reg, fin_last_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lclk_s1_reg <= 1'b0;
            lclk_s2_reg <= 1'b0;
            lclk_s3_reg <= 1'b0;
            fin_s1_reg <= 1'b0;
            fin_s2_reg <= 1'b0;
        end else if (ce) begin
            lclk_s1_reg <= rx_sys_common_clk;
            lclk_s2_reg <= lclk_s1_reg;
            lclk_s3_reg <= lclk_s2_reg;
            fin_s1_reg <= rx_common_frame_in;
            fin_s2_reg <= fin_s1_reg;
        end
    end

    // Both edges count, since the offset tables are in edges, not periods.
    wire link_edge = ce && (lclk_s2_reg != lclk_s3_reg);
    wire fin_evt = link_edge && fin_s2_reg && !fin_last_reg;

    // ==========================================================
    // Frame reference, delay to frame start, and bit position.
    logic [12:0] tmr_reg, dly_reg;
    logic dly_run_reg;
    logic [9:0] bitpos_reg;
    logic [1:0] ecnt_reg;
    logic started_reg;
    wire ref_own = link_edge && (tmr_reg == 13'h0000);
    wire ref_evt = frame_pulse_mode_eff ? fin_evt : ref_own;
    wire start_evt = link_edge && dly_run_reg && (dly_reg == 13'h0001) && !ref_evt;
    wire step_evt = link_edge && started_reg && (ecnt_reg == epb_last);
    wire bit_evt = start_evt || step_evt;
    wire [9:0] next_pos = (start_evt || bitpos_reg == 10'(FRAME_BITS - 1)) ? 10'h000 : bitpos_reg + 10'h001;
    wire first_bit = (next_pos == 10'h000);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmr_reg <= 13'h0000;
            fin_last_reg <= 1'b0;
        end else if (link_edge) begin
            tmr_reg <= (tmr_reg >= frame_last) ? 13'h0000 : tmr_reg + 13'h0001;
            fin_last_reg <= fin_s2_reg;
        end
    end

    // Frame start falls the programmed number of edges after the reference.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dly_reg <= 13'h0000;
            dly_run_reg <= 1'b0;
        end else if (ref_evt) begin
            dly_reg <= offset_edges;
            dly_run_reg <= 1'b1;
        end else if (link_edge && dly_run_reg) begin
            dly_reg <= dly_reg - 13'h0001;
            dly_run_reg <= (dly_reg != 13'h0001);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bitpos_reg <= 10'h000;
            ecnt_reg <= 2'h0;
            started_reg <= 1'b0;
        end else if (link_edge) begin
            ecnt_reg <= (bit_evt || ecnt_reg == epb_last) ? 2'h0 : ecnt_reg + 2'h1;
            started_reg <= started_reg || start_evt;
            if (bit_evt) begin
                bitpos_reg <= next_pos;
            end
        end
    end

    // ==========================================================
    // T1/J1 mode decode.
    wire t1_mux = t1_sel && (interface_mode == RXFMT_SLAVE_EXTSIG)
                  && ((!sysclk_2m_sel && sysclk_8m_sel) || (|peer_rate_mux_sel));
    wire t1_2m = t1_sel && sysclk_2m_sel && !sysclk_8m_sel;
    wire t1_master = t1_sel && !interface_mode[1];
    wire t1_cfg_err = t1_master && t1_2m;
    wire t1_frac = t1_master && (interface_mode == RXFMT_MASTER_FRAC);
    // Stuffing one dummy byte per three payload bytes lifts 1.544 to 2.048 Mb/s.
    wire t1_stuff = (t1_mux || (t1_2m && !t1_cfg_err)) && (next_pos[4:3] == 2'b00);
    // Fractional master only sends the slots the framer core marks.
    wire t1_skip = t1_frac && !rx_sig_in;

    // ==========================================================
    // First-bit processing: parity first, then forced polarity, then raw data.
    logic par_acc_reg;
    wire parity_allowed = parity_insert_en && !(frac_fbit_mode && !clk_master);
    wire par_bit = par_acc_reg ^ parity_type_sel;
    wire data_bit = t1_stuff ? 1'b1 : rx_bit_in;
    wire ins_bit = (first_bit && !t1_sel && parity_allowed) ? par_bit
                 : (first_bit && !t1_sel && force_first_bit_en) ? forced_bit_value
                 : data_bit;
    wire out_bit = rx_alarm_force_ones ? 1'b1 : ins_bit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            par_acc_reg <= 1'b0;
        end else if (bit_evt) begin
            par_acc_reg <= first_bit ? (parity_include_first_bit && ins_bit)
                                     : (par_acc_reg ^ ins_bit);
        end
    end

    // ==========================================================
    // Output pins. Signaling holds its last value while the alarm forces ones.
    logic data_out_reg, data_oe_n_reg, sig_out_reg, sig_oe_n_reg, take_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_out_reg <= 1'b1;
            sig_out_reg <= 1'b1;
            data_oe_n_reg <= 1'b1;
            sig_oe_n_reg <= 1'b1;
            take_reg <= 1'b0;
        end else if (ce) begin
            data_oe_n_reg <= tri_ctrl[0];
            sig_oe_n_reg <= tri_ctrl[1];
            take_reg <= bit_evt && !t1_stuff && !t1_skip;
            if (bit_evt && !t1_skip) begin
                data_out_reg <= out_bit;
            end
            if (bit_evt && !rx_alarm_force_ones) begin
                sig_out_reg <= rx_sig_in;
            end
        end
    end

    // ==========================================================
    // Frame pulse: own reference, aligned to data, or leading it.
    // The delay reads one at frame start, so a lead of n edges fires at n plus one.
    logic fp_out_reg;
    logic [1:0] fp_cnt_reg;
    wire fp_fire = lead_active ? (link_edge && dly_run_reg && dly_reg == lead_edges + 13'h0001)
                 : frame_pulse_mode_eff ? start_evt
                 : ref_own;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fp_out_reg <= 1'b0;
            fp_cnt_reg <= 2'h0;
        end else if (fp_fire) begin
            fp_out_reg <= 1'b1;
            fp_cnt_reg <= epb_last;
        end else if (link_edge) begin
            fp_out_reg <= fp_out_reg && (fp_cnt_reg != 2'h0);
            fp_cnt_reg <= (fp_cnt_reg == 2'h0) ? 2'h0 : fp_cnt_reg - 2'h1;
        end
    end

    // Status: T1 decode, alignment, and running parity accumulator.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= 8'h00;
            t1_mux_active <= 1'b0;
        end else if (ce) begin
            status_reg <= {3'b000, par_acc_reg, started_reg, t1_frac, t1_mux, t1_cfg_err};
            t1_mux_active <= t1_mux;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign rx_bit_take = take_reg;
    assign rx_sys_data_out = data_out_reg;
    assign rx_sys_data_oe_n = data_oe_n_reg;
    assign rx_sys_signaling_out = sig_out_reg;
    assign rx_sys_signaling_oe_n = sig_oe_n_reg;
    assign rx_frame_pulse_out = fp_out_reg;
endmodule
`default_nettype wire

// [tb/rxfmt_checker.sv]
// Checker for the output formatter: APB timing, alarm forcing and data tri-state.
// Assumes it is bound into rxfmt_top with the clock enable held high.
`timescale 1ns/1ps
`default_nettype none
module rxfmt_checker
    import rxfmt_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rx_bit_take,
    input wire logic rx_sys_data_out,
    input wire logic rx_sys_data_oe_n,
    input wire logic rx_sys_signaling_out
);
    logic alarm_reg;
    logic tri_reg;
    // Decode of committed writes to the two registers that are shadowed here.
    wire wr_done = psel && penable && pready && pwrite && !pslverr;
    wire hit_alarm = paddr == ADDR_W'({IDX_ALARM, 2'b00});
    wire hit_parity = paddr == ADDR_W'({IDX_PARITY, 2'b00});
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ==========================================================
    // Shadow copies, taken at the same edge at which the design commits a write.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_reg <= 1'b0;
            tri_reg <= 1'b0;
        end else if (wr_done) begin
            alarm_reg <= hit_alarm ? pwdata[ALARM_BIT] : alarm_reg;
            tri_reg <= hit_parity ? pwdata[0] : tri_reg;
        end
    end
    // ==========================================================
    // Assertions; the alarm ones wait two cycles so a bit already in flight is excused.
    a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("pready late");
    a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready held");
    a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
    a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0000_0000) else $error("prdata idle");
    a_misalign_refused: assert property (psel && !penable && paddr[1:0] != 2'b00 |=> pslverr)
        else $error("misaligned accepted");
    a_alarm_data_ones: assert property (alarm_reg && $past(alarm_reg, 2) && rx_bit_take |-> rx_sys_data_out)
        else $error("alarm data not one");
    a_alarm_sig_frozen: assert property (alarm_reg && $past(alarm_reg, 2) |-> $stable(rx_sys_signaling_out))
        else $error("signaling moved");
    a_data_tri_follow: assert property ($past(presetn) && $stable(tri_reg) |-> rx_sys_data_oe_n == tri_reg)
        else $error("data enable wrong");
    c_write_done: cover property (wr_done);
    c_refused: cover property (pslverr);
    c_alarm_take: cover property (alarm_reg && rx_bit_take);
endmodule
bind rxfmt_top rxfmt_checker #(.ADDR_W(ADDR_W)) u_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_bit_take(rx_bit_take), .rx_sys_data_out(rx_sys_data_out),
    .rx_sys_data_oe_n(rx_sys_data_oe_n), .rx_sys_signaling_out(rx_sys_signaling_out));
`default_nettype wire

// [tb/rxfmt_backplane.sv]
// Backplane model: free-running common clock and common frame pulse.
// Assumes the formatter samples both from its own clock domain.
`timescale 1ns/1ps
`default_nettype none
module rxfmt_backplane #(
    parameter int FRAME_BITS = 32
) (
    output logic sys_clk,
    output logic frame_pulse
);
    int bit_cnt = 0;
    // ==========================================================
    // A system clock runs free, so it does not stop between frames.
    initial begin
        frame_pulse = 1'b0;
        sys_clk = 1'b0;
        forever #80 sys_clk = ~sys_clk;
    end
    // One-bit active-high pulse on the first bit of every frame.
    always @(posedge sys_clk) begin
        frame_pulse <= (bit_cnt == 0);
        bit_cnt <= (bit_cnt + 1) % FRAME_BITS;
    end
endmodule
`default_nettype wire

// [tb/rxfmt_top_test.sv]
// Self-checking bench for the receive output formatter.
// Assumes the backplane model drives the common clock and frame pulse.
`timescale 1ns/1ps
`default_nettype none
module rxfmt_top_test;
    import rxfmt_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [6:0] peer_fpm = 7'h00;
    logic [6:0] peer_rate = 7'h00;
    logic bit_in = 1'b0;
    logic sig_in = 1'b0;
    logic [7:0] pat = 8'h00;
    logic [31:0] rd, prdata;
    logic er, pready, pslverr, take, dout, doe_n, sout, soe_n, fpo, t1mux, lclk, cfin;
    int num_errors = 0;
    int check_count = 0;
    rxfmt_backplane #(.FRAME_BITS(32)) u_bp (.sys_clk(lclk), .frame_pulse(cfin));
    rxfmt_top #(.FRAME_BITS(32)) DUT (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_sys_common_clk(lclk), .rx_common_frame_in(cfin), .peer_frame_pulse_mode(peer_fpm),
        .peer_rate_mux_sel(peer_rate), .rx_bit_in(bit_in), .rx_sig_in(sig_in), .rx_bit_take(take),
        .rx_sys_data_out(dout), .rx_sys_data_oe_n(doe_n), .rx_sys_signaling_out(sout),
        .rx_sys_signaling_oe_n(soe_n), .rx_frame_pulse_out(fpo), .t1_mux_active(t1mux));
    initial begin
        forever #5 pclk = ~pclk;
    end
    // A changing payload, so parity differs from frame to frame.
    always @(posedge pclk) begin
        if (take === 1'b1) begin
            pat <= pat + 8'h25;
            bit_in <= pat[5] ^ pat[0];
            sig_in <= pat[2];
        end
    end
    // ==========================================================
    // Verdict, comparison and bus tasks.
    task automatic tally_and_finish();
        if (num_errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Entered just after an edge; the request is held until pready is seen high.
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        num_errors += (n == 20);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        apb(1'b1, {idx, 2'b00}, d);
    endtask
    // Waits, bounded, for a low-to-high change seen at the clock edge.
    task automatic rise(ref logic s);
        int n = 0;
        while (s !== 1'b0 && n < 2000) begin
            @(posedge pclk);
            n++;
        end
        while (s !== 1'b1 && n < 2000) begin
            @(posedge pclk);
            n++;
        end
        num_errors += (n == 2000);
    endtask
    // One frame from the frame pulse, whose first bit stands at that same edge.
    task automatic grab(output logic [31:0] f);
        rise(fpo);
        for (int i = 31; i >= 0;) begin
            if (take === 1'b1) begin
                f[i] = dout;
                i--;
            end
            if (i >= 0) begin
                @(posedge pclk);
            end
        end
    endtask
    // ==========================================================
    // Scenarios.
    task automatic t_regs();
        logic [9:0] ix [4] = '{IDX_T1_MODE, IDX_PARITY, IDX_TIMESLOT_OFFSET, IDX_BIT_OFFSET_VAL};
        logic [7:0] mk [4] = '{MASK_T1_MODE, MASK_PARITY, MASK_TIMESLOT_OFFSET, MASK_BIT_OFFSET_VAL};
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, {ix[i], 2'b00}, 8'h00);
            cmp(rd, REG_RESET);
            wr(ix[i], 8'hFF);
            apb(1'b0, {ix[i], 2'b00}, 8'h00);
            cmp(rd, mk[i]);
            wr(ix[i], 8'h00);
        end
        apb(1'b1, 12'h3FC, 8'hFF);
        cmp(rd, 32'h0000_0000);
        cmp(er, 1'b1);
        apb(1'b0, 12'h049, 8'h00);
        cmp(er, 1'b1);
    endtask
    // Rows: frame cfg, edge cfg, bit offset, slot offset, system cfg (b2 also raises a peer's pulse mode).
    task automatic t_offset();
        logic [7:0] tb [6][5] = '{'{8'h20, 8'h00, 8'h0B, 8'h00, 8'h00}, '{8'h20, 8'h10, 8'h0F, 8'h01, 8'h00},
            '{8'h20, 8'h04, 8'h0F, 8'h00, 8'h00}, '{8'h20, 8'h14, 8'h03, 8'h01, 8'h00},
            '{8'h00, 8'h00, 8'h0A, 8'h00, 8'h04}, '{8'h25, 8'h10, 8'h00, 8'h01, 8'h00}};
        int e;
        longint t0;
        for (int r = 0; r < 6; r++) begin
            wr(IDX_FPCFG, tb[r][0]);
            wr(IDX_EDGE, tb[r][1]);
            wr(IDX_BIT_OFFSET_VAL, tb[r][2]);
            wr(IDX_TIMESLOT_OFFSET, tb[r][3]);
            wr(IDX_SYSCFG, tb[r][4]);
            peer_fpm <= {6'h00, tb[r][4][2]};
            e = (tb[r][1][4] ? 1 : 2) + ((tb[r][2][3] && !tb[r][1][2]) ? 2 * tb[r][2][2:0] : 0);
            e = e + tb[r][3] * (tb[r][1][2] ? 32 : 16) - ((tb[r][0][2] && tb[r][0][0]) ? (tb[r][1][4] ? 3 : 2) : 0);
            repeat (2) begin
                rise(cfin);
                t0 = $time;
                rise(fpo);
            end
            cmp(32'(($time - t0) / 80), 32'(e));
        end
    endtask
    task automatic t_parity();
        logic [7:0] pv [5] = '{8'h40, 8'hC8, 8'h70, 8'h20, 8'h30};
        logic [31:0] f0, f1;
        wr(IDX_FPCFG, 8'h20);
        for (int i = 0; i < 5; i++) begin
            wr(IDX_PARITY, pv[i]);
            grab(f0);
            grab(f0);
            grab(f1);
            cmp(f1[31], pv[i][6] ? ^(f0 & {pv[i][3], 31'h7FFF_FFFF}) ^ pv[i][7] : pv[i][4]);
        end
        wr(IDX_ALARM, 8'h02);
        grab(f0);
        grab(f0);
        cmp(f0, 32'hFFFF_FFFF);
        wr(IDX_ALARM, 8'h00);
        wr(IDX_PARITY, 8'h03);
        repeat (2) @(posedge pclk);
        cmp({doe_n, soe_n}, 2'b11);
        wr(IDX_PARITY, 8'h01);
        repeat (2) @(posedge pclk);
        cmp({doe_n, soe_n}, 2'b10);
    endtask
    task automatic t_t1();
        logic [7:0] tm [4] = '{8'hC8, 8'hC0, 8'h88, 8'h50};
        logic [7:0] sc [4] = '{8'h01, 8'h01, 8'h01, 8'h03};
        logic [1:0] ex [4] = '{2'b10, 2'b10, 2'b00, 2'b01};
        for (int i = 0; i < 4; i++) begin
            wr(IDX_T1_MODE, tm[i]);
            wr(IDX_SYSCFG, sc[i]);
            peer_rate <= {6'h00, i == 1};
            repeat (2) @(posedge pclk);
            apb(1'b0, {IDX_STATUS, 2'b00}, 8'h00);
            cmp({t1mux, rd[0]}, ex[i]);
        end
    endtask
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_offset();
        t_parity();
        t_t1();
        tally_and_finish();
    end
    // Watchdog: the run needs well under half of this span.
    initial begin
        #1_000_000;
        num_errors++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
